// [verilog/ifb_params.svh]
// Named offsets, bit positions, reset values and widths of the flag bank.
// Assumes it is included by the package and by each design module.
`ifndef IFB_PARAMS_SVH
`define IFB_PARAMS_SVH

`define IFB_ADDR_W 12
`define IFB_DATA_W 32
`define IFB_FLAG_W 16

`define IFB_OFF_FLAGS 12'h000
`define IFB_OFF_MASK 12'h004
`define IFB_OFF_CLEAR 12'h008

`define IFB_BIT_PARALLEL 13
`define IFB_BIT_COMPARE5 9
`define IFB_BIT_CAPTURE5 7
`define IFB_BIT_CAPTURE4 6
`define IFB_BIT_CAPTURE3 5
`define IFB_BIT_SERIAL_EVENT 1
`define IFB_BIT_SERIAL_FAULT 0

`define IFB_IMPL_MASK 16'h22e3
`define IFB_FLAGS_RESET 16'h0000
`define IFB_MASK_RESET 16'h0000
`define IFB_ZERO_HI 16'h0000
`define IFB_DATA_RESET 32'h0000_0000

`endif

// [verilog/ifb_pkg.sv]
// Types shared by the flag bank and its bus port.
// Assumes the constants header is on the include path.
`include "ifb_params.svh"

package ifb_pkg;

   typedef logic [`IFB_FLAG_W-1:0] ifb_flags_type;

   typedef enum {
      IFB_SEL_FLAGS,
      IFB_SEL_MASK,
      IFB_SEL_CLEAR,
      IFB_SEL_NONE
   } ifb_sel_type;

endpackage

// [verilog/ifb_apb_port.sv]
// APB slave port of the flag bank: address decode, write strobes, read data.
// Assumes a single 100 MHz clock and an APB master on the same clock.
`include "ifb_params.svh"

module ifb_apb_port
   import ifb_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // asynchronous reset, active low
   input wire logic psel, // slave select
   input wire logic penable, // access phase
   input wire logic pwrite, // write when high
   input wire logic [`IFB_ADDR_W-1:0] paddr, // byte address
   input wire ifb_flags_type flags, // current flag register
   input wire ifb_flags_type mask, // current mask register
   output logic [`IFB_DATA_W-1:0] prdata, // read data
   output logic pready, // transfer complete
   output logic pslverr, // unmapped address
   output logic wr_flags, // write strobe, flag register
   output logic wr_mask, // write strobe, mask register
   output logic wr_clear // write strobe, clear alias
);

   ifb_sel_type setup_sel;
   ifb_sel_type access_sel;
   logic access;

   function automatic ifb_sel_type decode(input logic [`IFB_ADDR_W-1:0] addr);
      case (addr)
         `IFB_OFF_FLAGS: decode = IFB_SEL_FLAGS;
         `IFB_OFF_MASK: decode = IFB_SEL_MASK;
         `IFB_OFF_CLEAR: decode = IFB_SEL_CLEAR;
         default: decode = IFB_SEL_NONE;
      endcase
   endfunction

   assign setup_sel = decode(paddr);
   assign access_sel = decode(paddr);
   assign access = psel && penable;

   // Every access completes in its first access cycle.
   assign pready = 1'b1;
   assign pslverr = access && (access_sel == IFB_SEL_NONE);

   assign wr_flags = access && pwrite && (access_sel == IFB_SEL_FLAGS);
   assign wr_mask = access && pwrite && (access_sel == IFB_SEL_MASK);
   assign wr_clear = access && pwrite && (access_sel == IFB_SEL_CLEAR);

   // Read data is captured in the setup cycle so it leaves a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `IFB_DATA_RESET;
      end else if (psel && !penable) begin
         if (pwrite) begin
            prdata <= `IFB_DATA_RESET;
         end else begin
            case (setup_sel)
               IFB_SEL_FLAGS: prdata <= {`IFB_ZERO_HI, flags};
               IFB_SEL_MASK: prdata <= {`IFB_ZERO_HI, mask};
               IFB_SEL_CLEAR: prdata <= {`IFB_ZERO_HI, flags};
               default: prdata <= `IFB_DATA_RESET;
            endcase
         end
      end
   end

endmodule

// [verilog/ifb_flag_bank.sv]
// Interrupt flag status bank two: seven sticky request flags with a mask
// and one level interrupt, reached over APB.
// Assumes peripheral request inputs are synchronous to pclk.
//
// What this block does
// - Bit 13 sets when the parallel port requests an interrupt.
// - Bit 9 holds the pending request of compare channel 5.
// - Bit 7 latches a request from capture channel 5.
// - Bit 6 latches a request from capture channel 4.
// - Bit 5 latches a request from capture channel 3.
// - Bit 1 records the second serial port's transfer event request.
// - Bit 0 records the second serial port's fault request, separately.
// - Bits 15-14, 12-10, 8 and 4-2 read zero and ignore writes.
// - One means pending, zero means none; all flags readable and writable.
`include "ifb_params.svh"

module ifb_flag_bank
   import ifb_pkg::*;
(
   input wire logic pclk, // system clock, 100 MHz
   input wire logic presetn, // asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [`IFB_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [`IFB_DATA_W-1:0] pwdata, // APB write data
   output logic [`IFB_DATA_W-1:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic parallel_port_irq_req, // parallel port request
   input wire logic compare5_irq_req, // compare channel 5 request
   input wire logic capture5_irq_req, // capture channel 5 request
   input wire logic capture4_irq_req, // capture channel 4 request
   input wire logic capture3_irq_req, // capture channel 3 request
   input wire logic serial_periph_b_event_req, // serial port B event
   input wire logic serial_periph_b_fault_req, // serial port B fault
   output logic irq // level interrupt
);

   ifb_flags_type peripheral_irq_flags_two;
   ifb_flags_type irq_mask;
   ifb_flags_type next_flags;
   ifb_flags_type event_vec;
   ifb_flags_type write_value;
   logic wr_flags;
   logic wr_mask;
   logic wr_clear;

   logic parallel_port_irq_flag;
   logic compare5_irq_flag;
   logic capture5_irq_flag;
   logic capture4_irq_flag;
   logic capture3_irq_flag;
   logic serial_periph_b_event_flag;
   logic serial_periph_b_fault_flag;

   ifb_apb_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .flags(peripheral_irq_flags_two),
      .mask(irq_mask),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .wr_flags(wr_flags),
      .wr_mask(wr_mask),
      .wr_clear(wr_clear)
   );

   assign write_value = pwdata[`IFB_FLAG_W-1:0];

   // Place each peripheral request at its flag position.
   always_comb begin
      event_vec = `IFB_FLAGS_RESET;
      event_vec[`IFB_BIT_PARALLEL] = parallel_port_irq_req;
      event_vec[`IFB_BIT_COMPARE5] = compare5_irq_req;
      event_vec[`IFB_BIT_CAPTURE5] = capture5_irq_req;
      event_vec[`IFB_BIT_CAPTURE4] = capture4_irq_req;
      event_vec[`IFB_BIT_CAPTURE3] = capture3_irq_req;
      event_vec[`IFB_BIT_SERIAL_EVENT] = serial_periph_b_event_req;
      event_vec[`IFB_BIT_SERIAL_FAULT] = serial_periph_b_fault_req;
   end

   // A request in the same cycle as a software clear keeps its flag set.
   always_comb begin
      next_flags = peripheral_irq_flags_two;
      if (wr_flags) begin
         next_flags = write_value;
      end else if (wr_clear) begin
         next_flags = peripheral_irq_flags_two & ~write_value;
      end
      next_flags = next_flags | event_vec;
      next_flags = next_flags & `IFB_IMPL_MASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_irq_flags_two <= `IFB_FLAGS_RESET;
      end else begin
         peripheral_irq_flags_two <= next_flags;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= `IFB_MASK_RESET;
      end else if (wr_mask) begin
         irq_mask <= write_value & `IFB_IMPL_MASK;
      end
   end

   assign irq = |(peripheral_irq_flags_two & irq_mask);

   assign parallel_port_irq_flag = peripheral_irq_flags_two[`IFB_BIT_PARALLEL];
   assign compare5_irq_flag = peripheral_irq_flags_two[`IFB_BIT_COMPARE5];
   assign capture5_irq_flag = peripheral_irq_flags_two[`IFB_BIT_CAPTURE5];
   assign capture4_irq_flag = peripheral_irq_flags_two[`IFB_BIT_CAPTURE4];
   assign capture3_irq_flag = peripheral_irq_flags_two[`IFB_BIT_CAPTURE3];
   assign serial_periph_b_event_flag = peripheral_irq_flags_two[`IFB_BIT_SERIAL_EVENT];
   assign serial_periph_b_fault_flag = peripheral_irq_flags_two[`IFB_BIT_SERIAL_FAULT];

   default clocking cb @(posedge pclk);
   endclocking

   default disable iff (!presetn);

   // A software write that stores zero into a flag, with no request beside it.
   sequence parallel_write_zero;
      wr_flags && !write_value[`IFB_BIT_PARALLEL] && !parallel_port_irq_req;
   endsequence

   sequence parallel_request_seen;
      parallel_port_irq_req ##1 parallel_port_irq_flag;
   endsequence

   sequence fault_clear_by_one;
      wr_clear && write_value[`IFB_BIT_SERIAL_FAULT] && !serial_periph_b_fault_req;
   endsequence

   parallel_set_a: assert property (
      parallel_port_irq_req |=> parallel_port_irq_flag)
      else $error("parallel port flag not set after request");

   parallel_cycle_a: assert property (
      parallel_request_seen ##0 (!parallel_port_irq_req [*2]) ##0 parallel_write_zero
         |=> !parallel_port_irq_flag)
      else $error("parallel port flag not cleared by a zero write");

   compare5_set_a: assert property (
      compare5_irq_req |=> compare5_irq_flag && (!irq_mask[`IFB_BIT_COMPARE5] || irq))
      else $error("compare 5 flag or interrupt missing after request");

   capture5_set_a: assert property (
      capture5_irq_req |=> capture5_irq_flag)
      else $error("capture 5 flag not set after request");

   capture4_set_a: assert property (
      capture4_irq_req |=> capture4_irq_flag)
      else $error("capture 4 flag not set after request");

   capture3_set_a: assert property (
      capture3_irq_req |=> capture3_irq_flag)
      else $error("capture 3 flag not set after request");

   serial_event_set_a: assert property (
      serial_periph_b_event_req |=> serial_periph_b_event_flag)
      else $error("serial event flag not set after request");

   serial_fault_alone_a: assert property (
      serial_periph_b_fault_req && !serial_periph_b_event_req && !serial_periph_b_event_flag
         && !wr_flags && !wr_clear
         |=> serial_periph_b_fault_flag && !serial_periph_b_event_flag)
      else $error("serial fault and event flags not kept apart");

   fault_clear_one_a: assert property (
      fault_clear_by_one |=> !serial_periph_b_fault_flag)
      else $error("serial fault flag not cleared by a one to the clear alias");

   unused_bits_zero_a: assert property (
      ((peripheral_irq_flags_two & ~`IFB_IMPL_MASK) == `IFB_FLAGS_RESET)
         && ((irq_mask & ~`IFB_IMPL_MASK) == `IFB_FLAGS_RESET))
      else $error("an unused flag or mask bit is set");

   unused_read_zero_a: assert property (
      psel && penable && !pwrite |-> (prdata[`IFB_FLAG_W-1:0] & ~`IFB_IMPL_MASK) == `IFB_FLAGS_RESET)
      else $error("an unused bit reads as one");

   write_value_a: assert property (
      wr_flags |=> peripheral_irq_flags_two
         == (($past(write_value) | $past(event_vec)) & `IFB_IMPL_MASK))
      else $error("flag register does not hold the written value");

   read_value_a: assert property (
      psel && !penable && !pwrite && (paddr == `IFB_OFF_FLAGS)
         |=> prdata == {`IFB_ZERO_HI, $past(peripheral_irq_flags_two)})
      else $error("flag read does not return the register");

   flags_hold_a: assert property (
      !wr_flags && !wr_clear
         |=> (peripheral_irq_flags_two & $past(peripheral_irq_flags_two))
            == $past(peripheral_irq_flags_two))
      else $error("a flag dropped without a software clear");

   set_beats_clear_a: assert property (
      wr_flags && (event_vec != `IFB_FLAGS_RESET)
         |=> (peripheral_irq_flags_two & $past(event_vec)) == $past(event_vec))
      else $error("a request was lost to a clear in the same cycle");

   mask_write_a: assert property (
      wr_mask |=> irq_mask == ($past(write_value) & `IFB_IMPL_MASK))
      else $error("mask register does not hold the written value");

   irq_level_a: assert property (
      irq == ((peripheral_irq_flags_two & irq_mask) != `IFB_FLAGS_RESET))
      else $error("interrupt does not follow the masked flags");

   unmapped_error_a: assert property (
      psel && penable && (paddr != `IFB_OFF_FLAGS) && (paddr != `IFB_OFF_MASK)
         && (paddr != `IFB_OFF_CLEAR) |-> pslverr && pready)
      else $error("unmapped address does not answer with an error");

   unmapped_quiet_a: assert property (
      pslverr && (event_vec == `IFB_FLAGS_RESET) |=> $stable(peripheral_irq_flags_two) && $stable(irq_mask))
      else $error("an unmapped write changed the flags");

   clear_alias_a: assert property (
      wr_clear |=> peripheral_irq_flags_two
         == ((($past(peripheral_irq_flags_two) & ~$past(write_value)) | $past(event_vec)) & `IFB_IMPL_MASK))
      else $error("clear alias did not drop exactly the flags written as one");

   // The disable is switched off here so that the reset values themselves are checked.
   reset_clear_a: assert property (disable iff (1'b0)
      !presetn |=> (peripheral_irq_flags_two == `IFB_FLAGS_RESET) && (irq_mask == `IFB_MASK_RESET)
         && !irq && (prdata == `IFB_DATA_RESET))
      else $error("flags, mask or read data not cleared by reset");

   no_spurious_set_a: assert property (
      !wr_flags |=> (peripheral_irq_flags_two & ~$past(peripheral_irq_flags_two) & ~$past(event_vec))
         == `IFB_FLAGS_RESET)
      else $error("a flag rose with no request and no software write");

   // An unmasked request while the mask is left alone.
   sequence masked_request;
      ((event_vec & irq_mask) != `IFB_FLAGS_RESET) && !wr_mask;
   endsequence

   irq_raise_a: assert property (
      masked_request |=> irq)
      else $error("interrupt not raised after an unmasked request");

   read_mask_a: assert property (
      psel && !penable && !pwrite && (paddr == `IFB_OFF_MASK)
         |=> prdata == {`IFB_ZERO_HI, $past(irq_mask)})
      else $error("mask read does not return the register");

   read_alias_a: assert property (
      psel && !penable && !pwrite && (paddr == `IFB_OFF_CLEAR)
         |=> prdata == {`IFB_ZERO_HI, $past(peripheral_irq_flags_two)})
      else $error("clear alias read does not return the flags");

   mapped_no_error_a: assert property (
      psel && penable && ((paddr == `IFB_OFF_FLAGS) || (paddr == `IFB_OFF_MASK) || (paddr == `IFB_OFF_CLEAR))
         |-> !pslverr && pready)
      else $error("mapped address answered with an error");

   mask_hold_a: assert property (
      !wr_mask |=> $stable(irq_mask))
      else $error("mask changed without a mask write");

   one_strobe_a: assert property (
      $onehot0({wr_flags, wr_mask, wr_clear}))
      else $error("more than one write strobe in a cycle");

   upper_read_zero_a: assert property (
      prdata[`IFB_DATA_W-1:`IFB_FLAG_W] == `IFB_ZERO_HI)
      else $error("read data above the flag register is not zero");

   compare5_zero_a: assert property (
      wr_flags && !write_value[`IFB_BIT_COMPARE5] && !compare5_irq_req |=> !compare5_irq_flag)
      else $error("compare 5 flag not cleared by a zero write");

   capture5_zero_a: assert property (
      wr_flags && !write_value[`IFB_BIT_CAPTURE5] && !capture5_irq_req |=> !capture5_irq_flag)
      else $error("capture 5 flag not cleared by a zero write");

   capture4_zero_a: assert property (
      wr_flags && !write_value[`IFB_BIT_CAPTURE4] && !capture4_irq_req |=> !capture4_irq_flag)
      else $error("capture 4 flag not cleared by a zero write");

   capture3_zero_a: assert property (
      wr_flags && !write_value[`IFB_BIT_CAPTURE3] && !capture3_irq_req |=> !capture3_irq_flag)
      else $error("capture 3 flag not cleared by a zero write");

   serial_event_zero_a: assert property (
      wr_flags && !write_value[`IFB_BIT_SERIAL_EVENT] && !serial_periph_b_event_req
         |=> !serial_periph_b_event_flag)
      else $error("serial event flag not cleared by a zero write");

endmodule

// [sim/ifb_periph_model.sv]
// Behavioural model of the peripherals that raise interrupt requests.
// Assumes the bench commands it synchronously to pclk.
module ifb_periph_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // asynchronous reset, active low
   input wire logic go, // start a request burst
   input wire logic [6:0] fire, // sources that fire
   input wire logic [1:0] len, // extra cycles a request stays high
   output logic parallel_req, // parallel port request
   output logic compare5_req, // compare channel 5 request
   output logic capture5_req, // capture channel 5 request
   output logic capture4_req, // capture channel 4 request
   output logic capture3_req, // capture channel 3 request
   output logic event_req, // serial port B event request
   output logic fault_req // serial port B fault request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] pattern;
   logic [2:0] left;

   // A burst lasts one to four cycles, so both pulse and level sources are seen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pattern <= 7'h00;
         left <= 3'h0;
      end else if (go) begin
         pattern <= fire;
         left <= {1'b0, len} + 3'h1;
      end else if (left != 3'h0) begin
         left <= left - 3'h1;
      end
   end

   assign {parallel_req, compare5_req, capture5_req, capture4_req, capture3_req, event_req, fault_req} =
      pattern & {7{left != 3'h0}};
endmodule

// [sim/ifb_flag_bank_tb.sv]
// Self-checking bench for the flag bank: APB master, request model, random mix.
// Assumes the design's package and constants header are compiled first.
`include "ifb_params.svh"

module ifb_flag_bank_tb
   import ifb_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic [`IFB_ADDR_W-1:0] paddr = 12'h000;
   logic [`IFB_DATA_W-1:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, irq, err;
   logic [6:0] fire = 7'h00;
   wire logic [6:0] req;
   logic [1:0] len = 2'h0;
   ifb_flags_type model, mask_model;
   int fails = 0, samples_checked = 0;

   always #5 pclk = ~pclk;

   ifb_flag_bank i_ifb_flag_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .parallel_port_irq_req(req[6]), .compare5_irq_req(req[5]), .capture5_irq_req(req[4]),
      .capture4_irq_req(req[3]), .capture3_irq_req(req[2]), .serial_periph_b_event_req(req[1]),
      .serial_periph_b_fault_req(req[0]), .irq(irq));

   ifb_periph_model i_ifb_periph_model (.pclk(pclk), .presetn(presetn), .go(go), .fire(fire), .len(len),
      .parallel_req(req[6]), .compare5_req(req[5]), .capture5_req(req[4]), .capture4_req(req[3]),
      .capture3_req(req[2]), .event_req(req[1]), .fault_req(req[0]));

   function automatic ifb_flags_type req_bits(logic [6:0] f);
      req_bits = 16'h0000;
      req_bits[`IFB_BIT_PARALLEL] = f[6];
      req_bits[`IFB_BIT_COMPARE5] = f[5];
      req_bits[`IFB_BIT_CAPTURE5] = f[4];
      req_bits[`IFB_BIT_CAPTURE4] = f[3];
      req_bits[`IFB_BIT_CAPTURE3] = f[2];
      req_bits[`IFB_BIT_SERIAL_EVENT] = f[1];
      req_bits[`IFB_BIT_SERIAL_FAULT] = f[0];
   endfunction

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(logic wr, logic [`IFB_ADDR_W-1:0] addr, logic [31:0] data);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic fire_req(logic [6:0] f, logic [1:0] l);
      @(posedge pclk);
      fire <= f;
      len <= l;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (6) @(posedge pclk);
      model = model | req_bits(f);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      wrap_up;
   end

   initial begin
      void'($urandom(62));
      model = 16'h0000;
      mask_model = 16'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
      chk("flags after reset", 32'h0, rd);
      chk("mapped read error", 32'h0, {31'h0, err});
      apb(1'b1, `IFB_OFF_MASK, 32'h0000_ffff);
      mask_model = 16'hffff;
      // Each source alone, with request lengths of one to four cycles, then cleared.
      for (int i = 0; i < 7; i++) begin
         fire_req(7'h01 << i, i[1:0]);
         apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
         chk("single flag", {16'h0, model}, rd);
         chk("irq on flag", 32'h1, {31'h0, irq});
         apb(1'b1, `IFB_OFF_CLEAR, {16'h0, req_bits(7'h01 << i)});
         model = 16'h0000;
         apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
         chk("flag cleared", 32'h0, rd);
      end
      apb(1'b1, `IFB_OFF_FLAGS, 32'hffff_ffff);
      model = `IFB_IMPL_MASK;
      apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
      chk("unused bits", {16'h0, model}, rd);
      apb(1'b0, `IFB_OFF_CLEAR, 32'h0);
      chk("alias read", {16'h0, model}, rd);
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      chk("unmapped write error", 32'h1, {31'h0, err});
      apb(1'b0, 12'h002, 32'h0);
      chk("unmapped read error", 32'h1, {31'h0, err});
      chk("unmapped read data", 32'h0, rd);
      apb(1'b1, `IFB_OFF_FLAGS, 32'h0);
      model = 16'h0000;
      apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
      chk("flags written zero", 32'h0, rd);
      // A request in the cycle of a zero write keeps its flag set.
      fork
         fire_req(7'h40, 2'h0);
         apb(1'b1, `IFB_OFF_FLAGS, 32'h0);
      join
      model = req_bits(7'h40);
      apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
      chk("set beats clear", {16'h0, model}, rd);
      // A zero write two cycles after a one-cycle request clears the flag.
      fork
         fire_req(7'h40, 2'h0);
         begin
            repeat (2) @(posedge pclk);
            apb(1'b1, `IFB_OFF_FLAGS, 32'h0);
         end
      join
      model = 16'h0000;
      apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
      chk("zero write after request", 32'h0, rd);
      // Random mix of requests, flag writes, alias clears and mask changes.
      for (int k = 0; k < 40; k++) begin
         logic [31:0] r;
         r = $urandom;
         case (r[1:0])
            2'h0: fire_req(r[8:2], r[10:9]);
            2'h1: begin
               apb(1'b1, `IFB_OFF_FLAGS, r);
               model = r[15:0] & `IFB_IMPL_MASK;
            end
            2'h2: begin
               apb(1'b1, `IFB_OFF_CLEAR, r);
               model = model & ~r[15:0];
            end
            default: begin
               apb(1'b1, `IFB_OFF_MASK, r);
               mask_model = r[15:0];
               apb(1'b0, `IFB_OFF_MASK, 32'h0);
               chk("mask readback", {16'h0, mask_model & `IFB_IMPL_MASK}, rd);
            end
         endcase
         apb(1'b0, `IFB_OFF_FLAGS, 32'h0);
         chk("random flags", {16'h0, model}, rd);
         chk("random irq", {31'h0, |(model & mask_model)}, {31'h0, irq});
      end
      wrap_up;
   end
endmodule
